// ===== logic/iog_params.svh
// Address windows, register bits and timing counts for the I/O card glue.
// Assumes a 10 MHz core clock; every count below is derived from it.
`ifndef IOG_PARAMS_SVH
`define IOG_PARAMS_SVH
// Address windows, inclusive bounds
`define IOG_RTC_A_LO   10'h340
`define IOG_RTC_A_HI   10'h35F
`define IOG_RTC_B_LO   10'h2C0
`define IOG_RTC_B_HI   10'h2DF
`define IOG_SER_A_LO   10'h3F8
`define IOG_SER_A_HI   10'h3FF
`define IOG_SER_B_LO   10'h2F8
`define IOG_SER_B_HI   10'h2FF
`define IOG_PRN_H_LO   10'h378
`define IOG_PRN_H_HI   10'h37A
`define IOG_PRN_L_LO   10'h3BC
`define IOG_PRN_L_HI   10'h3BF
`define IOG_FDC_LO     10'h3F4
`define IOG_FDC_HI     10'h3F5
`define IOG_DOR_ADDR   10'h3F2
// Digital output register layout and reset value
`define IOG_DOR_RST    8'h00
`define IOG_DOR_NRES   2
`define IOG_DOR_DMA    3
`define IOG_DOR_MOT_A  4
`define IOG_DOR_MOT_B  5
// Timing: core clock and derived counts
`define IOG_CLK_NS     100
`define IOG_CLK_PS     100000
`define IOG_WRCLK_NS   2000
`define IOG_WRCLK_CYC  (`IOG_WRCLK_NS / `IOG_CLK_NS)
`define IOG_WIN_NS     4000
`define IOG_WIN_CYC    (`IOG_WIN_NS / `IOG_CLK_NS)
`define IOG_PRECOMP_NS 250
`define IOG_PRECOMP_CYC (`IOG_PRECOMP_NS / `IOG_CLK_NS)
`define IOG_SEP_PS     62500
`define IOG_SEP_CYC    ((`IOG_SEP_PS + `IOG_CLK_PS - 1) / `IOG_CLK_PS)
`endif

// ===== logic/iog_pkg.sv
// Types shared by the I/O card glue.
// Assumes nothing beyond the parameter header.
package iog_pkg;
    // Host I/O bus pins
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] data;
        logic       aen_n;
        logic       ior_n;
        logic       iow_n;
        logic       dack2_n;
        logic       tc;
    } iog_host_type;
    // Loose pins from board, controller and drive
    typedef struct packed {
        logic prn_en;
        logic prn_base;
        logic prn_irq;
        logic ser_ref;
        logic fosc;
        logic dreq;
        logic psel0;
        logic psel1;
        logic fwe;
        logic fwd;
        logic raw_n;
    } iog_pins_type;
    // Active-low chip selects
    typedef struct packed {
        logic clock_chip_sel_a;
        logic clock_chip_sel_b;
        logic serial_sel_a;
        logic serial_sel_b;
        logic printer_sel;
    } iog_sel_type;
    // Registered decode and floppy control outputs
    typedef struct packed {
        iog_sel_type sel;
        logic [3:0]  clock_reg_idx;
        logic        io_cycle_n;
        logic        fctl_write_n;
        logic        fctl_read_n;
        logic        fctl_term_count;
        logic        fctl_dma_ack;
        logic        fctl_reset;
        logic        partial_drive_sel_a;
        logic        partial_drive_sel_b;
        logic        motor_on_a;
        logic        motor_on_b;
        logic        dma_req;
        logic        dma_req_oe_n;
        logic        dma_req_gate_n;
        logic        floppy_irq_gate_n;
        logic        printer_irq;
        logic        printer_irq_oe_n;
        logic        printer_irq_gate_n;
    } iog_out_type;
endpackage

// ===== logic/iog_top.sv
// Address decode, clock division and floppy support glue of the I/O card.
// Assumes bus and loose pin inputs are asynchronous; each passes two flip-flops.
`include "iog_params.svh"

module iog_top (
    input  wire logic                  core_clk_in,
    input  wire logic                  sys_rst_in,
    input  wire iog_pkg::iog_host_type host_in,
    input  wire logic                  printer_port_enable_in,
    input  wire logic                  printer_base_select_in,
    input  wire logic                  printer_irq_req_in,
    input  wire logic                  serial_ref_in,
    input  wire logic                  floppy_osc_in,
    input  wire logic                  fctl_dma_req_in,
    input  wire logic                  precomp_sel0_in,
    input  wire logic                  precomp_sel1_in,
    input  wire logic                  fctl_write_en_in,
    input  wire logic                  fctl_write_data_in,
    input  wire logic                  raw_read_data_n_in,
    output iog_pkg::iog_out_type       ctl_out,
    output logic                       serial_clk_out,
    output logic                       floppy_ctl_clk_out,
    output logic                       fctl_write_clock_out,
    output logic                       drive_write_en_out,
    output logic                       drive_write_data_out,
    output logic                       sep_data_out_n_out,
    output logic                       data_window_out
);
    import iog_pkg::*;

    localparam int DL = 2 * `IOG_PRECOMP_CYC + 1; // Delay line length
    localparam int WIN_HALF = `IOG_WIN_CYC / 2;   // Window half period

    // Inclusive range test
    function automatic logic in_rng(input logic [9:0] a, input logic [9:0] lo,
                                    input logic [9:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    iog_host_type h1, h2;       // Host bus synchroniser
    iog_pins_type p_raw;        // Loose pins gathered
    iog_pins_type p1, p2, p3;   // Pin synchroniser, p3 for edges
    iog_out_type  o, next_o;    // Registered control outputs
    logic [7:0]   dor, next_dor; // Digital output register
    logic         cpu, dma;     // Qualified cycle kinds
    logic         fdc_hit, prn_hit;

    assign p_raw = '{prn_en: printer_port_enable_in, prn_base: printer_base_select_in,
                     prn_irq: printer_irq_req_in, ser_ref: serial_ref_in,
                     fosc: floppy_osc_in, dreq: fctl_dma_req_in,
                     psel0: precomp_sel0_in, psel1: precomp_sel1_in,
                     fwe: fctl_write_en_in, fwd: fctl_write_data_in,
                     raw_n: raw_read_data_n_in};
    assign ctl_out = o;

    // Two-flop synchronisers; idle bus resets to all ones
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            h1 <= '1;
            h2 <= '1;
            p1 <= '0;
            p2 <= '0;
            p3 <= '0;
        end
        else
        begin
            h1 <= host_in;
            h2 <= h1;
            p1 <= p_raw;
            p2 <= p1;
            p3 <= p2;
        end
    end

    // Decode and floppy control, next values
    always_comb
    begin
        cpu = !h2.aen_n;
        dma = !h2.dack2_n;
        fdc_hit = in_rng(h2.addr, `IOG_FDC_LO, `IOG_FDC_HI);
        // Base select moves the printer window
        prn_hit = p2.prn_base ? in_rng(h2.addr, `IOG_PRN_H_LO, `IOG_PRN_H_HI)
                              : in_rng(h2.addr, `IOG_PRN_L_LO, `IOG_PRN_L_HI);
        next_o = o;
        // Selects depend on address, address enable and printer pins, not strobes
        next_o.sel.clock_chip_sel_a =
            !(cpu && in_rng(h2.addr, `IOG_RTC_A_LO, `IOG_RTC_A_HI));
        next_o.sel.clock_chip_sel_b =
            !(cpu && in_rng(h2.addr, `IOG_RTC_B_LO, `IOG_RTC_B_HI));
        next_o.sel.serial_sel_a =
            !(cpu && in_rng(h2.addr, `IOG_SER_A_LO, `IOG_SER_A_HI));
        next_o.sel.serial_sel_b =
            !(cpu && in_rng(h2.addr, `IOG_SER_B_LO, `IOG_SER_B_HI));
        next_o.sel.printer_sel = !(cpu && p2.prn_en && prn_hit);
        // Only four low bits reach the clock chip
        next_o.clock_reg_idx = h2.addr[3:0];
        next_o.io_cycle_n = h2.ior_n & h2.iow_n;
        // DMA write to controller is an I/O write under acknowledge
        next_o.fctl_write_n = !((cpu && fdc_hit && !h2.iow_n) ||
                                (dma && !h2.iow_n));
        next_o.fctl_read_n = !((cpu && fdc_hit && !h2.ior_n) ||
                               (dma && !h2.ior_n));
        next_o.fctl_term_count = dma && h2.tc;
        next_o.fctl_dma_ack = dma;
        next_o.fctl_reset = !dor[`IOG_DOR_NRES];
        // Board completes the select with the motor bit
        next_o.partial_drive_sel_a = (dor[1:0] == 2'h0);
        next_o.partial_drive_sel_b = (dor[1:0] == 2'h1);
        next_o.motor_on_a = dor[`IOG_DOR_MOT_A];
        next_o.motor_on_b = dor[`IOG_DOR_MOT_B];
        // Request drives only while enabled and pending
        next_o.dma_req = p2.dreq && dor[`IOG_DOR_DMA];
        next_o.dma_req_oe_n = !(p2.dreq && dor[`IOG_DOR_DMA]);
        next_o.dma_req_gate_n = !dor[`IOG_DOR_DMA];
        next_o.floppy_irq_gate_n = !dor[`IOG_DOR_DMA];
        // Printer interrupt drives high only when active
        next_o.printer_irq = p2.prn_en && p2.prn_irq;
        next_o.printer_irq_oe_n = !(p2.prn_en && p2.prn_irq);
        next_o.printer_irq_gate_n = !(p2.prn_en && p2.prn_irq);
        // Held strobe rewrites the same byte, so no edge is needed
        next_dor = dor;
        if (cpu && !h2.iow_n && (h2.addr == `IOG_DOR_ADDR))
        begin
            next_dor = h2.data;
        end
    end

    // Decode and floppy control registers
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            o <= '{sel: '1, io_cycle_n: 1'b1, fctl_write_n: 1'b1, fctl_read_n: 1'b1,
                   fctl_reset: 1'b1, dma_req_oe_n: 1'b1, dma_req_gate_n: 1'b1,
                   floppy_irq_gate_n: 1'b1, printer_irq_oe_n: 1'b1,
                   printer_irq_gate_n: 1'b1, default: '0};
            dor <= `IOG_DOR_RST;
        end
        else
        begin
            o <= next_o;
            dor <= next_dor;
        end
    end

    logic       ser_clk, next_ser_clk; // Serial clock
    logic       fclk, next_fclk;       // Controller clock
    logic [4:0] wr_cnt, next_wr_cnt;   // Write clock phase
    logic       wr_clk, next_wr_clk;   // Write clock pulse

    // Clock dividers; inputs are sampled, so jitter is one core cycle
    always_comb
    begin
        next_ser_clk = ser_clk;
        if (p2.ser_ref && !p3.ser_ref)
        begin
            next_ser_clk = !ser_clk;
        end
        // Sampling 16 MHz at the 10 MHz core clock folds it onto 4 MHz,
        // so the sampled oscillator itself is the controller clock
        // Limitation: duty is 2/5 or 3/5, edges jitter by one core cycle
        next_fclk = p2.fosc;
        // One-cycle pulse every period
        next_wr_cnt = (wr_cnt == 5'(`IOG_WRCLK_CYC - 1)) ? 5'h00 : wr_cnt + 5'h01;
        next_wr_clk = (wr_cnt == 5'h00);
    end

    // Clock divider registers
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            ser_clk <= 1'b0;
            fclk <= 1'b0;
            wr_cnt <= 5'h00;
            wr_clk <= 1'b0;
        end
        else
        begin
            ser_clk <= next_ser_clk;
            fclk <= next_fclk;
            wr_cnt <= next_wr_cnt;
            wr_clk <= next_wr_clk;
        end
    end

    logic [1:0]    sep_cnt, next_sep_cnt; // Pulse length left
    logic          sep_n, next_sep_n;     // Separated data
    logic [5:0]    win_cnt, next_win_cnt; // Window phase
    logic          win, next_win;         // Data window
    logic          raw_fall;              // Raw data flux edge
    logic [DL-1:0] dl, next_dl;           // Write data delay line
    logic          dwd, next_dwd;
    logic          drive_write_en, next_dwe;

    // Separator and precompensation, next values
    always_comb
    begin
        raw_fall = !p2.raw_n && p3.raw_n;
        next_sep_cnt = (sep_cnt != 2'h0) ? sep_cnt - 2'h1 : 2'h0;
        next_win_cnt = (win_cnt == 6'(`IOG_WIN_CYC - 1)) ? 6'h00 : win_cnt + 6'h01;
        if (raw_fall)
        begin
            next_sep_cnt = 2'(`IOG_SEP_CYC);
            // Recentre so the flux edge falls mid half-window
            next_win_cnt = 6'(WIN_HALF / 2);
        end
        next_sep_n = (next_sep_cnt == 2'h0);
        next_win = (next_win_cnt < 6'(WIN_HALF));
        next_dl = {dl[DL-2:0], p2.fwd};
        // Nominal tap is the centre, so shift never exceeds the bound
        case ({p2.psel1, p2.psel0})
            2'b01: next_dwd = dl[0];
            2'b10: next_dwd = dl[DL-1];
            default: next_dwd = dl[`IOG_PRECOMP_CYC];
        endcase
        next_dwe = p2.fwe;
    end

    // Separator and precompensation registers
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            sep_cnt <= 2'h0;
            sep_n <= 1'b1;
            win_cnt <= 6'h00;
            win <= 1'b0;
            dl <= '0;
            dwd <= 1'b0;
            drive_write_en <= 1'b0;
        end
        else
        begin
            sep_cnt <= next_sep_cnt;
            sep_n <= next_sep_n;
            win_cnt <= next_win_cnt;
            win <= next_win;
            dl <= next_dl;
            dwd <= next_dwd;
            drive_write_en <= next_dwe;
        end
    end

    assign serial_clk_out = ser_clk;
    assign floppy_ctl_clk_out = fclk;
    assign fctl_write_clock_out = wr_clk;
    assign sep_data_out_n_out = sep_n;
    assign data_window_out = win;
    assign drive_write_data_out = dwd;
    assign drive_write_en_out = drive_write_en;

    // Output checks; host pins reach the clock chip selects and I/O-cycle indicator three cycles later
    a_rtc_a_sel: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        o.sel.clock_chip_sel_a == !(!$past(host_in.aen_n, 3) &&
        in_rng($past(host_in.addr, 3), `IOG_RTC_A_LO, `IOG_RTC_A_HI)))
        else $error("clock chip A select wrong");
    a_rtc_b_sel: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        o.sel.clock_chip_sel_b == !(!$past(host_in.aen_n, 3) &&
        in_rng($past(host_in.addr, 3), `IOG_RTC_B_LO, `IOG_RTC_B_HI)))
        else $error("clock chip B select wrong");
    a_ser_a_sel: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !o.sel.serial_sel_a |-> $past(h2.addr[9:3]) == 7'h7F && !$past(h2.aen_n))
        else $error("serial A select wrong");
    a_ser_b_sel: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !o.sel.serial_sel_b |-> $past(h2.addr[9:3]) == 7'h5F && !$past(h2.aen_n))
        else $error("serial B select wrong");
    a_io_cycle: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        o.io_cycle_n == ($past(host_in.ior_n, 3) & $past(host_in.iow_n, 3)))
        else $error("I/O cycle indicator wrong");
    a_dor_reset: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (!h2.aen_n && !h2.iow_n && h2.addr == `IOG_DOR_ADDR && !h2.data[2])
        |-> ##2 o.fctl_reset) else $error("controller reset not raised");
    a_wrclk_gap: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        wr_clk |=> !wr_clk [*8]) else $error("write clock pulse too wide");
    a_wrclk_per: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        wr_clk |-> ##20 wr_clk) else $error("write clock period wrong");
    a_sep_pulse: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        $fell(sep_n) |=> sep_n) else $error("separated pulse length wrong");
    a_precomp_early: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ($past(p2.psel0) && !$past(p2.psel1)) |-> dwd == $past(p2.fwd, 2))
        else $error("early precompensation wrong");
    a_tc_gate: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        o.fctl_term_count |-> $past(!h2.dack2_n && h2.tc))
        else $error("terminal count outside DMA");
    c_rtc_sel: cover property (@(posedge core_clk_in) $fell(o.sel.clock_chip_sel_a));
    c_dor_reset: cover property (@(posedge core_clk_in) $rose(o.fctl_reset));
    c_sep: cover property (@(posedge core_clk_in) $fell(sep_n));
    c_prn_irq: cover property (@(posedge core_clk_in) $rose(o.printer_irq));
endmodule // iog_top

// ===== tb/iog_host_model.sv
// Host bus and board oscillator model facing the I/O card glue.
// Assumes the bench calls its task only after reset has been released.
module iog_host_model (
    input  wire logic             clk_in,
    output iog_pkg::iog_host_type host_out,
    output logic                  ref_out,
    output logic                  osc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import iog_pkg::*;

    // Serial reference, free running, unrelated to the core clock
    initial
    begin
        ref_out = 1'b0;
        forever #135.634 ref_out = ~ref_out;
    end

    // Floppy oscillator, free running
    initial
    begin
        osc_out = 1'b0;
        // Offset keeps its edges off the core clock edges
        #10;
        forever #31.25 osc_out = ~osc_out;
    end

    // Idle bus: strobes high, no DMA
    initial host_out = {10'h3FF, 8'hFF, 5'h1E};

    // One cycle, held six edges so the input synchronisers catch it
    task automatic cycle(input logic [9:0] a, input logic [7:0] d, input logic aen_n,
                         input logic rd, input logic wr, input logic dack, input logic tc);
        @(negedge clk_in);
        host_out = {a, d, aen_n, !rd, !wr, !dack, tc};
        repeat (6) @(negedge clk_in);
        // Released lines float: show the inverse, never the stale value
        host_out = {~a, ~d, 5'h1E};
        repeat (4) @(negedge clk_in);
    endtask
endmodule // iog_host_model

// ===== tb/io_card_decode_glue_bench.sv
// Self-checking bench of the I/O card glue: decode, floppy control, clocks.
// Assumes the host model owns bus and oscillators; the rest is driven here.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module io_card_decode_glue_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import iog_pkg::*;
    // Expected result of one bus cycle
    typedef struct packed {
        iog_sel_type sel;
        logic        wr_n;
        logic        rd_n;
        logic        idx_on;  // Index only meaningful in a clock window
        logic [3:0]  idx;
    } iog_note_type;
    logic         core_clk_in, sys_rst_in, serial_ref_in, floppy_osc_in;
    iog_host_type host_in;
    logic         printer_port_enable_in, printer_base_select_in, printer_irq_req_in;
    logic         fctl_dma_req_in, raw_read_data_n_in, precomp_sel0_in, precomp_sel1_in;
    logic         fctl_write_en_in, fctl_write_data_in;
    iog_out_type  ctl_out;
    logic         serial_clk_out, floppy_ctl_clk_out, fctl_write_clock_out, data_window_out;
    logic         drive_write_en_out, drive_write_data_out, sep_data_out_n_out;
    logic         drive_a_sel_n;  // Board gate: qualified drive A select
    logic         ps, pw, pd, pf; // Previous samples for edge counting
    int           error_cnt, comparisons, k, t_a, t_b, n_a, n_b, n_c;
    iog_note_type notes[$];
    iog_note_type note;
    logic [7:0]   dor, data;
    logic [9:0]   addr_tab [26] = '{10'h33F, 10'h340, 10'h350, 10'h35F, 10'h360, 10'h2BF,
        10'h2C0, 10'h2CF, 10'h2DF, 10'h2E0, 10'h2F7, 10'h2F8, 10'h2FF, 10'h3F7, 10'h3F8,
        10'h3FF, 10'h377, 10'h378, 10'h37A, 10'h37B, 10'h3BB, 10'h3BC, 10'h3BF, 10'h3F4,
        10'h3F5, 10'h3F6};

    assign drive_a_sel_n = !(ctl_out.partial_drive_sel_a && ctl_out.motor_on_a);

    iog_top i_dut (.core_clk_in, .sys_rst_in, .host_in, .printer_port_enable_in,
        .printer_base_select_in, .printer_irq_req_in, .serial_ref_in, .floppy_osc_in,
        .fctl_dma_req_in, .precomp_sel0_in, .precomp_sel1_in, .fctl_write_en_in,
        .fctl_write_data_in, .raw_read_data_n_in, .ctl_out,
        .serial_clk_out, .floppy_ctl_clk_out, .fctl_write_clock_out, .drive_write_en_out,
        .drive_write_data_out, .sep_data_out_n_out, .data_window_out);
    iog_host_model i_host (.clk_in(core_clk_in), .host_out(host_in), .ref_out(serial_ref_in),
        .osc_out(floppy_osc_in));

    // 10 MHz core clock
    initial
    begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    // Hang guard, far above the whole run
    initial
    begin
        #2000000;
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen hang");
        end_of_test();
    end

    // Verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Decode outcome worked out from the address windows
    function automatic iog_note_type expect_of(input logic [9:0] a, input logic aen_n,
                                               input logic rd, input logic wr, input logic dk);
        iog_note_type n;
        logic         c;
        logic         p;
        c = !aen_n;
        p = printer_base_select_in ? (a >= 10'h378 && a <= 10'h37A)
                                   : (a >= 10'h3BC && a <= 10'h3BF);
        n.sel.clock_chip_sel_a = !(c && a >= 10'h340 && a <= 10'h35F);
        n.sel.clock_chip_sel_b = !(c && a >= 10'h2C0 && a <= 10'h2DF);
        n.sel.serial_sel_a = !(c && a >= 10'h3F8);
        n.sel.serial_sel_b = !(c && a >= 10'h2F8 && a <= 10'h2FF);
        n.sel.printer_sel = !(c && printer_port_enable_in && p);
        n.wr_n = !(wr && ((c && a[9:1] == 9'h1FA) || dk));
        n.rd_n = !(rd && ((c && a[9:1] == 9'h1FA) || dk));
        n.idx_on = !(n.sel.clock_chip_sel_a && n.sel.clock_chip_sel_b);
        n.idx = a[3:0];
        return n;
    endfunction

    // Driver side: note the expectation, then run the cycle
    task automatic bus(input logic [9:0] a, input logic [7:0] d, input logic aen_n,
                       input logic rd, input logic wr, input logic dk, input logic tc);
        notes.push_back(expect_of(a, aen_n, rd, wr, dk));
        i_host.cycle(a, d, aen_n, rd, wr, dk, tc);
    endtask

    // Every fall of the I/O-cycle indicator settles the oldest note
    always @(negedge ctl_out.io_cycle_n)
    begin
        @(negedge core_clk_in);
        `CHK("note present", 1'b1, notes.size() > 0)
        if (notes.size() > 0)
        begin
            note = notes.pop_front();
            `CHK("selects", note.sel, ctl_out.sel)
            `CHK("strobes", {note.wr_n, note.rd_n},
                {ctl_out.fctl_write_n, ctl_out.fctl_read_n})
            if (note.idx_on)
                `CHK("clock index", note.idx, ctl_out.clock_reg_idx)
        end
    end

    initial
    begin
        void'($urandom(98857));
        sys_rst_in = 1'b1;
        {printer_port_enable_in, printer_base_select_in, printer_irq_req_in} = 3'h6;
        {fctl_dma_req_in, precomp_sel0_in, precomp_sel1_in, fctl_write_en_in} = 4'h0;
        {fctl_write_data_in, raw_read_data_n_in} = 2'h1;
        repeat (6) @(negedge core_clk_in);
        `CHK("reset selects", 5'h1F, ctl_out.sel)
        `CHK("reset floppy", 7'h43, {ctl_out.fctl_reset, ctl_out.motor_on_a, ctl_out.motor_on_b,
            ctl_out.dma_req, ctl_out.printer_irq, ctl_out.dma_req_gate_n,
            ctl_out.printer_irq_gate_n})
        sys_rst_in = 1'b0;
        $display("test reset done");
        // Window edges under each printer setting; writes, then reads
        for (int m = 0; m < 3; m++)
        begin
            {printer_port_enable_in, printer_base_select_in} = 2'(m + 1);
            foreach (addr_tab[i])
                bus(addr_tab[i], 8'h00, 1'b0, m == 2, m != 2, 1'b0, 1'b0);
        end
        // Random reads, address enable random, so some are refused
        repeat (30)
            bus(10'($urandom), 8'h00, 1'($urandom), 1'b1, 1'b0, 1'b0, 1'b0);
        $display("test decode done");
        // DMA reads and writes inside a clock window; selects stay off
        for (int m = 0; m < 4; m++)
        fork
            bus(10'h340, 8'h00, 1'b1, m[0], !m[0], 1'b1, m[1]);
            begin
                repeat (5) @(negedge core_clk_in);
                `CHK("terminal count", m[1], ctl_out.fctl_term_count)
                `CHK("dma ack", 1'b1, ctl_out.fctl_dma_ack)
            end
        join
        $display("test dma done");
        // Output register writes; the last one lacks address enable
        for (int i = 0; i < 9; i++)
        begin
            data = (i == 0) ? 8'h00 : (8'($urandom) | (i[0] ? 8'h08 : 8'h00));
            fctl_dma_req_in = i[0];
            bus(10'h3F2, data, i == 8, 1'b0, 1'b1, 1'b0, 1'b0);
            if (i < 8)
                dor = data;
            `CHK("register outputs", {!dor[2], dor[5:4], dor[1:0] == 2'h0, dor[1:0] == 2'h1,
                !dor[3], !dor[3]}, {ctl_out.fctl_reset, ctl_out.motor_on_b, ctl_out.motor_on_a,
                ctl_out.partial_drive_sel_a, ctl_out.partial_drive_sel_b, ctl_out.dma_req_gate_n,
                ctl_out.floppy_irq_gate_n})
            `CHK("dma request", {i[0] & dor[3], !(i[0] & dor[3])},
                {ctl_out.dma_req, ctl_out.dma_req_oe_n})
            `CHK("drive a select", !(dor[1:0] == 2'h0 && dor[4]), drive_a_sel_n)
        end
        $display("test output register done");
        for (int i = 0; i < 4; i++)
        begin
            {printer_port_enable_in, printer_irq_req_in} = 2'(i);
            repeat (5) @(negedge core_clk_in);
            `CHK("printer irq", (i == 3) ? 3'h4 : 3'h3, {ctl_out.printer_irq,
                ctl_out.printer_irq_oe_n, ctl_out.printer_irq_gate_n})
        end
        printer_irq_req_in = 1'b0;
        $display("test printer irq done");
        // Each precompensation mode: measure edges seen after the drive edge
        for (int m = 0; m < 4; m++)
        begin
            {precomp_sel1_in, precomp_sel0_in} = 2'(m);
            repeat (5) @(negedge core_clk_in);
            {fctl_write_en_in, fctl_write_data_in, t_a, t_b} = {2'h3, 64'h0};
            for (k = 1; k <= 12; k++)
            begin
                @(negedge core_clk_in);
                if (drive_write_en_out === 1'b1 && t_a == 0)
                    t_a = k;
                if (drive_write_data_out === 1'b1 && t_b == 0)
                    t_b = k;
            end
            `CHK("write enable delay", 3, t_a)
            `CHK("write data delay", (m == 1) ? 4 : (m == 2) ? 8 : 6, t_b)
            `CHK("shift limit", 1'b1, (t_b - 6) * 100 <= 250 && (6 - t_b) * 100 <= 250)
            {fctl_write_en_in, fctl_write_data_in} = 2'h0;
            repeat (12) @(negedge core_clk_in);
        end
        $display("test precomp done");
        // Flux edges at two window phases
        for (int r = 0; r < 2; r++)
        begin
            repeat (7 + r * 13) @(negedge core_clk_in);
            {raw_read_data_n_in, n_a, n_b, t_a} = 97'h0;
            for (k = 1; k <= 16; k++)
            begin
                @(negedge core_clk_in);
                raw_read_data_n_in = (k >= 2);
                if (sep_data_out_n_out === 1'b0)
                    {n_a, t_a} = {n_a + 1, k};
                if (data_window_out === 1'b1 && k >= 3)
                    n_b++;
            end
            `CHK("sep pulses", 1, n_a)
            `CHK("sep pulse time", 3, t_a)
            `CHK("window realign", 10, n_b)
        end
        $display("test separator done");
        // Free-running clocks over 1000 cycles
        {n_a, n_b, n_c, t_a, t_b} = 160'h0;
        {ps, pw, pd, pf} = {serial_clk_out, fctl_write_clock_out, data_window_out,
            floppy_ctl_clk_out};
        for (k = 0; k < 1000; k++)
        begin
            @(negedge core_clk_in);
            n_a += (serial_clk_out && !ps);
            n_b += (fctl_write_clock_out && !pw);
            n_c += (data_window_out && !pd);
            t_a += (floppy_ctl_clk_out && !pf);
            t_b += (fctl_write_clock_out === 1'b1);
            {ps, pw, pd, pf} = {serial_clk_out, fctl_write_clock_out, data_window_out,
                floppy_ctl_clk_out};
        end
        `CHK("serial clock", 1'b1, n_a >= 182 && n_a <= 186)
        `CHK("floppy clock", 1'b1, t_a >= 399 && t_a <= 401)
        `CHK("write clock", 50, n_b)
        `CHK("write pulse width", 50, t_b)
        `CHK("data window", 25, n_c)
        $display("test clocks done");
        repeat (4) @(negedge core_clk_in);
        `CHK("notes left", 0, notes.size())
        end_of_test();
    end
endmodule // io_card_decode_glue_bench
